// ===== isrp_bus_master.sv
`timescale 1ns/1ns
// =====
// two-wire master model; pins move on clk falls, so a bit is 20 cycles
module isrp_bus_master (
  input  wire logic clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_oe
);
  // idle bus: clock parked high, data released
  initial begin
    scl    = 1'b1;
    sda_oe = 1'b0;
  end

  task automatic go(input int n);
    repeat (n) @(negedge clk);
  endtask

  // data moves mid-low, stable across rise
  task automatic put_bit(input logic b);
    go(5);
    sda_oe = ~b;
    go(5);
    scl = 1'b1;
    go(10);
    scl = 1'b0;
  endtask

  // released while the far end drives
  task automatic get_bit(output logic b);
    go(5);
    sda_oe = 1'b0;
    go(5);
    scl = 1'b1;
    go(5);
    b = sda;
    go(5);
    scl = 1'b0;
  endtask

  task automatic start();
    go(5);
    sda_oe = 1'b0;
    go(5);
    scl = 1'b1;
    go(5);
    sda_oe = 1'b1;
    go(5);
    scl = 1'b0;
  endtask

  task automatic stop();
    go(5);
    sda_oe = 1'b1;
    go(5);
    scl = 1'b1;
    go(5);
    sda_oe = 1'b0;
    go(5);
  endtask

  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      put_bit(d[i]);
    end
    get_bit(b);
    ack = ~b;
  endtask

  // master acks to continue, nacks to end
  task automatic get_byte(output logic [7:0] d, input logic ack);
    for (int i = 7; i >= 0; i--) begin
      get_bit(d[i]);
    end
    put_bit(~ack);
  endtask
endmodule // isrp_bus_master

// ===== isrp_defines.svh
`ifndef ISRP_DEFINES_SVH
`define ISRP_DEFINES_SVH
// ==========================================
// slave address and register offsets
`define ISRP_DEV_ADDR  7'h43
`define ISRP_A_SIL_VER 8'h00
`define ISRP_A_PART_ID 8'h01
`define ISRP_A_CS_CTL  8'h05
`define ISRP_A_CS_DIVA 8'h06
`define ISRP_A_CS_DIVB 8'h07
`define ISRP_A_EDGE    8'h0d
`define ISRP_A_ERR     8'h0f
`define ISRP_A_SRST    8'h10
`define ISRP_A_PLAY    8'h13
`define ISRP_A_SILENCE 8'h14
`define ISRP_A_AUXREF  8'h16
`define ISRP_A_LOCK    8'h40
`define ISRP_A_AUXC_L  8'h41
`define ISRP_A_AUXC_H  8'h42
`define ISRP_A_HDR_H   8'h43
`define ISRP_A_HDR_M   8'h44
`define ISRP_A_HDR_L   8'h45
`define ISRP_A_LGA     8'h46
`define ISRP_A_LGB     8'h47
`define ISRP_A_RGA     8'h48
`define ISRP_A_RGB     8'h49
`define ISRP_A_SDIV    8'h54
`define ISRP_A_OFMT    8'h55
`define ISRP_A_XOVER   8'h56
`define ISRP_A_AUXD0   8'h59
`define ISRP_A_AUXD1   8'h5a
`define ISRP_A_AUXD2   8'h5b
`define ISRP_A_AUXD3   8'h5c
`define ISRP_A_AUXD4   8'h5d
`define ISRP_A_OCLKF   8'h61
`define ISRP_A_CONVCLK 8'h63
`define ISRP_A_FRAC_L  8'h64
`define ISRP_A_FRAC_H  8'h65
`define ISRP_A_FCNT_L  8'h67
`define ISRP_A_FCNT_M  8'h68
`define ISRP_A_FCNT_H  8'h69
`define ISRP_A_RATE    8'h6a
`define ISRP_A_FWREV   8'h71
`define ISRP_A_RUN     8'h72
`define ISRP_A_HSC_L   8'h77
`define ISRP_A_HSC_H   8'h78
`define ISRP_A_LSC_L   8'h79
`define ISRP_A_LSC_H   8'h7a
`define ISRP_A_HSBST   8'h7b
`define ISRP_A_LSBST   8'h7c
`define ISRP_A_SHATT   8'h7d
// ==========================================
// reset values, and the index of the last bit of a byte
`define ISRP_R_ZERO    8'h00
`define ISRP_R_CS_CTL  8'h21
`define ISRP_R_CS_DIVA 8'h0c
`define ISRP_R_EDGE    8'h04
`define ISRP_R_PLAY    8'h01
`define ISRP_R_GAIN_B  8'hff
`define ISRP_R_SDIV    8'h01
`define ISRP_R_OFMT    8'h21
`define ISRP_R_OCLKF   8'h0f
`define ISRP_R_FRAC_L  8'hc8
`define ISRP_R_FRAC_H  8'h59
`define ISRP_LAST_BIT  3'h7
`endif

// ===== isrp_pkg.sv
package isrp_pkg;
`include "isrp_defines.svh"
  typedef enum logic [2:0] {S_IDLE, S_RX, S_RXDONE, S_ACK, S_TX, S_MACK, S_IGNORE} isrp_st_t;
  typedef enum logic [1:0] {K_SEL, K_SUB, K_DATA} isrp_kind_t;
  typedef struct packed {
    logic [7:0] cs_ctl, cs_diva, cs_divb, edge_sel;
    logic [7:0] play_en, silence, aux_refr;
    logic [7:0] lgain_a, lgain_b, rgain_a, rgain_b;
    logic [7:0] sclk_div, out_fmt, xover, oclk_f, conv_clk;
    logic [7:0] frac_l, frac_h, dec_run;
    logic [7:0] hs_cl, hs_ch, ls_cl, ls_ch, hs_boost, ls_boost, shelf_att;
  } isrp_ctrl_t;
  typedef struct packed {
    logic [7:0] sil_ver, err_stat, lock, auxc_l, auxc_h;
    logic [7:0] hdr_h, hdr_m, hdr_l;
    logic [7:0] auxd0, auxd1, auxd2, auxd3, auxd4;
    logic [7:0] fcnt_l, fcnt_m, fcnt_h, rate, fw_rev;
  } isrp_stat_t;
  typedef struct packed {
    logic       valid;
    logic [7:0] addr;
    logic [7:0] data;
  } isrp_wr_t;
  typedef struct packed {
    logic [2:0] scl_p;
    logic [2:0] sda_p;
    isrp_st_t   st;
    isrp_kind_t kind;
    logic [2:0] cnt;
    logic [7:0] sh;
    logic [7:0] tx;
    logic [7:0] ptr;
    logic       rd;
    logic       oe;
    logic       sda_o;
    logic       soft_rst;
    isrp_wr_t   wr;
    isrp_ctrl_t ctrl;
  } isrp_state_t;
  localparam isrp_ctrl_t ISRP_CTRL_RST = '{
    cs_ctl: `ISRP_R_CS_CTL, cs_diva: `ISRP_R_CS_DIVA, edge_sel: `ISRP_R_EDGE,
    play_en: `ISRP_R_PLAY, lgain_b: `ISRP_R_GAIN_B, rgain_b: `ISRP_R_GAIN_B,
    sclk_div: `ISRP_R_SDIV, out_fmt: `ISRP_R_OFMT, oclk_f: `ISRP_R_OCLKF,
    frac_l: `ISRP_R_FRAC_L, frac_h: `ISRP_R_FRAC_H, default: `ISRP_R_ZERO};
endpackage : isrp_pkg

// ===== isrp_top.sv
`timescale 1ns/1ns
// What this block does
// - sda changes while scl high are start or stop, never data
// - sda falling with scl high is a start; restarts byte reception
// - sda rising with scl high is a stop; ends the transfer
// - after eight bits transmitter releases sda; receiver pulls low on ninth
// - device samples sda on scl rising edge when receiving
// - select byte msb first, upper seven bits are address 1000011
// - select byte lsb one means read, zero means write
// - device acknowledges select byte only when address matches
// - byte after write select loads register address, acknowledged
// - single data byte is acknowledged and stored, then master stops
// - multibyte write stores successive bytes at successive addresses until stop
// - byte address counter increments after each byte written or read
// - read select returns register at counter address
// - master ack continues with next address; nack then stop ends
// - sequential read follows current or random address read alike
// - all registers 8 bits, accessed as whole bytes only
// - registers take listed reset values; unlisted ones reset to zero
module isrp_top
  import isrp_pkg::*;
#(
  parameter int         DEV_ADDR = `ISRP_DEV_ADDR,
  // arbitrary value, not a real part code
  parameter logic [7:0] PART_ID  = 8'h5a
) (
  input  wire logic                 CLK,
  input  wire logic                 NRST,
  input  wire logic                 SCL_I,
  input  wire logic                 SDA_I,
  output logic                      SDA_O,
  output logic                      SDA_OE,
  input  wire isrp_pkg::isrp_stat_t STAT,
  output isrp_pkg::isrp_ctrl_t      CTRL,
  output isrp_pkg::isrp_wr_t        WR,
  output logic                      SOFT_RST_P
);
  import isrp_pkg::*;

  if (DEV_ADDR < 0 || DEV_ADDR > 127) begin : g_chk
    $error("DEV_ADDR must fit in seven bits");
  end

  localparam logic [6:0] MY_ADDR = DEV_ADDR[6:0];
  localparam isrp_wr_t WR_RST = '{valid: 1'b0, addr: `ISRP_R_ZERO, data: `ISRP_R_ZERO};
  // sync chains reset high so no false edge appears at release
  localparam isrp_state_t ST_RST = '{
    scl_p: 3'h7, sda_p: 3'h7, st: S_IDLE, kind: K_SEL, cnt: 3'h0,
    sh: `ISRP_R_ZERO, tx: `ISRP_R_ZERO, ptr: `ISRP_R_ZERO, rd: 1'b0,
    oe: 1'b0, sda_o: 1'b0, soft_rst: 1'b0, wr: WR_RST, ctrl: ISRP_CTRL_RST};

  isrp_state_t q;
  isrp_state_t d;
  logic        scl2;
  logic        scl3;
  logic        sda2;
  logic        sda3;
  logic        scl_r;
  logic        scl_f;
  logic        start;
  logic        stop;

  // ==========================================
  // register read and write decode
  // whole bytes only
  function automatic logic [7:0] rd_val(input logic [7:0] a, input isrp_ctrl_t c,
                                        input isrp_stat_t s);
    logic [7:0] v;
    v = `ISRP_R_ZERO;
    case (a)
      `ISRP_A_SIL_VER: v = s.sil_ver;
      `ISRP_A_PART_ID: v = PART_ID;
      `ISRP_A_CS_CTL:  v = c.cs_ctl;
      `ISRP_A_CS_DIVA: v = c.cs_diva;
      `ISRP_A_CS_DIVB: v = c.cs_divb;
      `ISRP_A_EDGE:    v = c.edge_sel;
      `ISRP_A_ERR:     v = s.err_stat;
      `ISRP_A_PLAY:    v = c.play_en;
      `ISRP_A_SILENCE: v = c.silence;
      `ISRP_A_AUXREF:  v = c.aux_refr;
      `ISRP_A_LOCK:    v = s.lock;
      `ISRP_A_AUXC_L:  v = s.auxc_l;
      `ISRP_A_AUXC_H:  v = s.auxc_h;
      `ISRP_A_HDR_H:   v = s.hdr_h;
      `ISRP_A_HDR_M:   v = s.hdr_m;
      `ISRP_A_HDR_L:   v = s.hdr_l;
      `ISRP_A_LGA:     v = c.lgain_a;
      `ISRP_A_LGB:     v = c.lgain_b;
      `ISRP_A_RGA:     v = c.rgain_a;
      `ISRP_A_RGB:     v = c.rgain_b;
      `ISRP_A_SDIV:    v = c.sclk_div;
      `ISRP_A_OFMT:    v = c.out_fmt;
      `ISRP_A_XOVER:   v = c.xover;
      `ISRP_A_AUXD0:   v = s.auxd0;
      `ISRP_A_AUXD1:   v = s.auxd1;
      `ISRP_A_AUXD2:   v = s.auxd2;
      `ISRP_A_AUXD3:   v = s.auxd3;
      `ISRP_A_AUXD4:   v = s.auxd4;
      `ISRP_A_OCLKF:   v = c.oclk_f;
      `ISRP_A_CONVCLK: v = c.conv_clk;
      `ISRP_A_FRAC_L:  v = c.frac_l;
      `ISRP_A_FRAC_H:  v = c.frac_h;
      `ISRP_A_FCNT_L:  v = s.fcnt_l;
      `ISRP_A_FCNT_M:  v = s.fcnt_m;
      `ISRP_A_FCNT_H:  v = s.fcnt_h;
      `ISRP_A_RATE:    v = s.rate;
      `ISRP_A_FWREV:   v = s.fw_rev;
      `ISRP_A_RUN:     v = c.dec_run;
      `ISRP_A_HSC_L:   v = c.hs_cl;
      `ISRP_A_HSC_H:   v = c.hs_ch;
      `ISRP_A_LSC_L:   v = c.ls_cl;
      `ISRP_A_LSC_H:   v = c.ls_ch;
      `ISRP_A_HSBST:   v = c.hs_boost;
      `ISRP_A_LSBST:   v = c.ls_boost;
      `ISRP_A_SHATT:   v = c.shelf_att;
      default:         v = `ISRP_R_ZERO;
    endcase
    return v;
  endfunction

  function automatic isrp_ctrl_t wr_ctrl(input isrp_ctrl_t c, input logic [7:0] a,
                                         input logic [7:0] v);
    isrp_ctrl_t n;
    n = c;
    case (a)
      `ISRP_A_CS_CTL:  n.cs_ctl    = v;
      `ISRP_A_CS_DIVA: n.cs_diva   = v;
      `ISRP_A_CS_DIVB: n.cs_divb   = v;
      `ISRP_A_EDGE:    n.edge_sel  = v;
      `ISRP_A_PLAY:    n.play_en   = v;
      `ISRP_A_SILENCE: n.silence   = v;
      `ISRP_A_AUXREF:  n.aux_refr  = v;
      `ISRP_A_LGA:     n.lgain_a   = v;
      `ISRP_A_LGB:     n.lgain_b   = v;
      `ISRP_A_RGA:     n.rgain_a   = v;
      `ISRP_A_RGB:     n.rgain_b   = v;
      `ISRP_A_SDIV:    n.sclk_div  = v;
      `ISRP_A_OFMT:    n.out_fmt   = v;
      `ISRP_A_XOVER:   n.xover     = v;
      `ISRP_A_OCLKF:   n.oclk_f    = v;
      `ISRP_A_CONVCLK: n.conv_clk  = v;
      `ISRP_A_FRAC_L:  n.frac_l    = v;
      `ISRP_A_FRAC_H:  n.frac_h    = v;
      `ISRP_A_RUN:     n.dec_run   = v;
      `ISRP_A_HSC_L:   n.hs_cl     = v;
      `ISRP_A_HSC_H:   n.hs_ch     = v;
      `ISRP_A_LSC_L:   n.ls_cl     = v;
      `ISRP_A_LSC_H:   n.ls_ch     = v;
      `ISRP_A_HSBST:   n.hs_boost  = v;
      `ISRP_A_LSBST:   n.ls_boost  = v;
      `ISRP_A_SHATT:   n.shelf_att = v;
      // soft reset drops the command registers back to idle
      `ISRP_A_SRST: begin
        n.dec_run  = `ISRP_R_ZERO;
        n.aux_refr = `ISRP_R_ZERO;
      end
      default:         n = c;
    endcase
    return n;
  endfunction

  // ==========================================
  // pin sampling and bus conditions
  // stage 0 feeds only stage 1; edges compare stages 1 and 2
  assign scl2  = q.scl_p[1];
  assign scl3  = q.scl_p[2];
  assign sda2  = q.sda_p[1];
  assign sda3  = q.sda_p[2];
  assign scl_r = scl2 & ~scl3;
  assign scl_f = ~scl2 & scl3;
  // sda moving under high scl is a condition
  assign start = scl2 & scl3 & sda3 & ~sda2;
  assign stop  = scl2 & scl3 & ~sda3 & sda2;

  // ==========================================
  // protocol engine
  always_comb begin
    d          = q;
    d.scl_p    = {q.scl_p[1:0], SCL_I};
    d.sda_p    = {q.sda_p[1:0], SDA_I};
    d.wr.valid = 1'b0;
    d.soft_rst = 1'b0;
    unique case (q.st)
      S_IDLE, S_IGNORE: begin
        d.oe = 1'b0;
      end
      S_RX: begin
        if (scl_r) begin
          d.sh  = {q.sh[6:0], sda2};
          d.cnt = q.cnt + 3'h1;
          if (q.cnt == `ISRP_LAST_BIT) begin
            d.st = S_RXDONE;
          end
        end
      end
      S_RXDONE: begin
        // ack driven from the fall after bit eight
        if (scl_f) begin
          unique case (q.kind)
            K_SEL: begin
              if (q.sh[7:1] == MY_ADDR) begin
                d.oe = 1'b1;
                d.st = S_ACK;
                d.rd = q.sh[0];
                if (q.sh[0]) begin
                  d.tx  = rd_val(q.ptr, q.ctrl, STAT);
                  d.ptr = q.ptr + 8'h01;
                end else begin
                  d.kind = K_SUB;
                end
              end else begin
                d.st = S_IGNORE;
              end
            end
            K_SUB: begin
              d.ptr  = q.sh;
              d.kind = K_DATA;
              d.oe   = 1'b1;
              d.st   = S_ACK;
            end
            K_DATA: begin
              d.ctrl    = wr_ctrl(q.ctrl, q.ptr, q.sh);
              d.wr      = '{valid: 1'b1, addr: q.ptr, data: q.sh};
              d.soft_rst = (q.ptr == `ISRP_A_SRST);
              d.ptr     = q.ptr + 8'h01;
              d.oe      = 1'b1;
              d.st      = S_ACK;
            end
            default: begin
              d.st = S_IGNORE;
            end
          endcase
        end
      end
      S_ACK: begin
        if (scl_f) begin
          d.cnt = 3'h0;
          if (q.rd) begin
            d.oe = ~q.tx[7];
            d.st = S_TX;
          end else begin
            d.oe = 1'b0;
            d.st = S_RX;
          end
        end
      end
      S_TX: begin
        if (scl_f) begin
          if (q.cnt == `ISRP_LAST_BIT) begin
            d.oe  = 1'b0;
            d.cnt = 3'h0;
            d.st  = S_MACK;
          end else begin
            d.cnt = q.cnt + 3'h1;
            d.tx  = {q.tx[6:0], 1'b0};
            d.oe  = ~q.tx[6];
          end
        end
      end
      S_MACK: begin
        if (scl_r) begin
          if (!sda2) begin
            // same path for both read entries
            d.tx  = rd_val(q.ptr, q.ctrl, STAT);
            d.ptr = q.ptr + 8'h01;
            d.st  = S_ACK;
          end else begin
            d.st = S_IGNORE;
          end
        end
      end
      default: begin
        d.st = S_IDLE;
      end
    endcase
    if (start) begin
      d.st   = S_RX;
      d.kind = K_SEL;
      d.cnt  = 3'h0;
      d.oe   = 1'b0;
      d.rd   = 1'b0;
    end else if (stop) begin
      d.st = S_IDLE;
      d.oe = 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      q <= ST_RST;
    end else begin
      q <= d;
    end
  end

  assign SDA_O      = q.sda_o;
  assign SDA_OE     = q.oe;
  assign CTRL       = q.ctrl;
  assign WR         = q.wr;
  assign SOFT_RST_P = q.soft_rst;

  // ==========================================
  // checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);

  a_start_rx_entry: assert property (
    start |=> q.st == S_RX && q.kind == K_SEL && q.cnt == 3'h0 && !SDA_OE)
    else $error("start did not restart reception");
  a_stop_ends_xfer: assert property (
    stop |=> q.st == S_IDLE && !SDA_OE)
    else $error("stop did not end transfer");
  a_oe_scl_low: assert property (
    $changed(SDA_OE) |-> $past(scl_f) || $past(start) || $past(stop))
    else $error("sda drive changed outside scl low");
  a_rise_sample: assert property (
    $changed(q.sh) |-> $past(scl_r) && $past(q.st) == S_RX)
    else $error("shift register moved off scl rise");
  a_sel_ack_match: assert property (
    (q.st == S_RXDONE && scl_f && q.kind == K_SEL && q.sh[7:1] == MY_ADDR && !start && !stop)
    |=> SDA_OE && q.st == S_ACK && q.rd == $past(q.sh[0]))
    else $error("matching select not acknowledged");
  a_sel_no_match: assert property (
    (q.st == S_RXDONE && scl_f && q.kind == K_SEL && q.sh[7:1] != MY_ADDR && !start && !stop)
    |=> q.st == S_IGNORE && !SDA_OE)
    else $error("mismatched select drove the bus");
  a_ignore_quiet: assert property (
    q.st == S_IGNORE |-> !SDA_OE)
    else $error("sda driven while ignoring");
  a_write_step: assert property (
    (q.st == S_RXDONE && scl_f && q.kind == K_DATA && !start && !stop)
    |=> WR.valid && WR.addr == $past(q.ptr) && WR.data == $past(q.sh) && q.ptr == WR.addr + 8'h01)
    else $error("write did not store and advance");
  a_tx_release: assert property (
    (q.st == S_TX && scl_f && q.cnt == `ISRP_LAST_BIT && !start && !stop) |=> !SDA_OE && q.st == S_MACK)
    else $error("transmitter kept sda after eight bits");
  a_nack_ends: assert property (
    (q.st == S_MACK && scl_r && sda2 && !start && !stop) |=> q.st == S_IGNORE ##1 !SDA_OE)
    else $error("read continued after nack");
  a_ack_release: assert property (
    (q.st == S_ACK && scl_f && !q.rd && !start && !stop) |=> !SDA_OE && q.st == S_RX)
    else $error("receiver ack held past ninth clock");
  a_sub_load: assert property (
    (q.st == S_RXDONE && scl_f && q.kind == K_SUB && !start && !stop) |=> SDA_OE && q.ptr == $past(q.sh))
    else $error("register address not loaded");
  a_read_count: assert property (
    (q.st == S_MACK && scl_r && !sda2 && !start && !stop) |=> q.ptr == $past(q.ptr) + 8'h01)
    else $error("counter did not advance on read");

  c_write_byte: cover property (WR.valid);
  c_read_select: cover property (q.st == S_ACK && q.rd);
  c_seq_read: cover property (q.st == S_MACK && scl_r && !sda2);
  c_nack_end: cover property (q.st == S_MACK && scl_r && sda2);
  c_foreign_sel: cover property (q.st == S_IGNORE && !q.rd);
endmodule // isrp_top

// ===== tb.sv
`timescale 1ns/1ns
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin num_errors++; $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb;
  import isrp_pkg::*;
  logic        clk;
  logic        nrst;
  logic        scl;
  logic        m_oe;
  logic        dev_o;
  logic        dev_oe;
  wire         sda;
  isrp_stat_t  stat;
  isrp_ctrl_t  ctrl;
  isrp_wr_t    wr;
  logic        srst_p;
  int          num_errors;
  int          compares;
  int          srst_cnt;
  logic        ack;
  logic [15:0] wr_ent;
  logic [15:0] wr_log[$];
  logic [7:0]  rd_v[0:7];
  logic [15:0] rst_tab[0:12] = '{16'h0521, 16'h060c, 16'h0d04, 16'h1301, 16'h4600, 16'h47ff, 16'h49ff,
                                 16'h5401, 16'h5521, 16'h610f, 16'h64c8, 16'h6559, 16'h013c};

  // open drain: any enable pulls low, pull-up otherwise
  assign sda = (dev_oe | m_oe) ? 1'b0 : 1'b1;

  // arbitrary identity value, not a real part code
  isrp_top #(.PART_ID(8'h3c)) u_isrp_top (
    .CLK        (clk),
    .NRST       (nrst),
    .SCL_I      (scl),
    .SDA_I      (sda),
    .SDA_O      (dev_o),
    .SDA_OE     (dev_oe),
    .STAT       (stat),
    .CTRL       (ctrl),
    .WR         (wr),
    .SOFT_RST_P (srst_p)
  );

  isrp_bus_master u_isrp_bus_master (
    .clk    (clk),
    .sda    (sda),
    .scl    (scl),
    .sda_oe (m_oe)
  );

  // =====
  // clock, watchdog, pulse monitor
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial begin
    repeat (60000) @(posedge clk);
    num_errors++;
    final_report();
  end

  // sampled mid-cycle so pulse edges never race the design
  always @(negedge clk) begin
    if (wr.valid === 1'b1) begin
      wr_log.push_back({wr.addr, wr.data});
    end
    if (srst_p === 1'b1) begin
      srst_cnt++;
    end
  end

  // =====
  // bus access tasks
  task automatic sel(input logic [6:0] a, input logic rd, input logic exp);
    u_isrp_bus_master.start();
    u_isrp_bus_master.put_byte({a, rd}, ack);
    `CHK(ack, exp)
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d0, input int n);
    sel(7'h43, 1'b0, 1'b1);
    u_isrp_bus_master.put_byte(a, ack);
    `CHK(ack, 1'b1)
    for (int i = 0; i < n; i++) begin
      u_isrp_bus_master.put_byte(d0 + 8'(i), ack);
      `CHK(ack, 1'b1)
    end
    u_isrp_bus_master.stop();
  endtask

  task automatic reg_rd(input logic [7:0] a, input logic rnd, input int n);
    if (rnd) begin
      sel(7'h43, 1'b0, 1'b1);
      u_isrp_bus_master.put_byte(a, ack);
      `CHK(ack, 1'b1)
    end
    sel(7'h43, 1'b1, 1'b1);
    for (int i = 0; i < n; i++) begin
      u_isrp_bus_master.get_byte(rd_v[i], i < n - 1);
    end
    u_isrp_bus_master.stop();
  endtask

  task automatic final_report();
    $display("compares=%0d num_errors=%0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // =====
  // test sequence
  initial begin
    nrst       = 1'b0;
    num_errors = 0;
    compares   = 0;
    srst_cnt   = 0;
    for (int i = 0; i < 18; i++) begin
      stat[i*8 +: 8] = 8'h80 + 8'(i);
    end
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    repeat (4) @(negedge clk);
    `CHK(ctrl, ISRP_CTRL_RST)
    `CHK(dev_o, 1'b0)
    foreach (rst_tab[i]) begin
      reg_rd(rst_tab[i][15:8], 1'b1, 1);
      `CHK(rd_v[0], rst_tab[i][7:0])
    end
    // live status bytes, read as one stream
    reg_rd(8'h40, 1'b1, 3);
    for (int i = 0; i < 3; i++) begin
      `CHK(rd_v[i], 8'h8f - 8'(i))
    end
    wr_log.delete();
    reg_wr(8'h46, 8'h5a, 1);
    `CHK(ctrl.lgain_a, 8'h5a)
    // popped once, since the compare macro reads its argument twice
    wr_ent = wr_log.pop_front();
    `CHK(wr_ent, 16'h465a)
    reg_wr(8'h77, 8'h10, 4);
    `CHK(ctrl.hs_cl, 8'h10)
    `CHK(ctrl.ls_ch, 8'h13)
    for (int i = 0; i < 4; i++) begin
      wr_ent = wr_log.pop_front();
      `CHK(wr_ent, {8'h77 + 8'(i), 8'h10 + 8'(i)})
    end
    reg_rd(8'h77, 1'b1, 3);
    for (int i = 0; i < 3; i++) begin
      `CHK(rd_v[i], 8'h10 + 8'(i))
    end
    // counter left one past the last byte sent
    reg_rd(8'h00, 1'b0, 2);
    `CHK(rd_v[0], 8'h13)
    `CHK(rd_v[1], 8'h00)
    // foreign addresses, one differing only in the top bit
    for (int i = 0; i < 2; i++) begin
      sel(i ? 7'h03 : 7'h42, 1'b0, 1'b0);
      u_isrp_bus_master.put_byte(8'h48, ack);
      `CHK(ack, 1'b0)
      u_isrp_bus_master.put_byte(8'ha5, ack);
      `CHK(ack, 1'b0)
      u_isrp_bus_master.stop();
    end
    `CHK(ctrl.rgain_a, 8'h00)
    `CHK(wr_log.size(), 0)
    reg_wr(8'h72, 8'h01, 1);
    `CHK(ctrl.dec_run, 8'h01)
    reg_wr(8'h10, 8'h01, 1);
    `CHK(srst_cnt, 1)
    `CHK(ctrl.dec_run, 8'h00)
    `CHK(dev_o, 1'b0)
    // second reset in mid-run
    nrst = 1'b0;
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    repeat (4) @(negedge clk);
    `CHK(ctrl, ISRP_CTRL_RST)
    reg_rd(8'h46, 1'b1, 1);
    `CHK(rd_v[0], 8'h00)
    final_report();
  end
endmodule // tb
